// ===== core/pport_consts.svh
// register offsets, field positions, reset values and codes of the parallel port
`ifndef PPORT_CONSTS_SVH
`define PPORT_CONSTS_SVH

// register word offsets
`define PP_REG_CTRL 4'h0
`define PP_REG_CS1_BASE 4'h1
`define PP_REG_CS2_BASE 4'h2
`define PP_REG_CS1_MODE 4'h3
`define PP_REG_CS2_MODE 4'h4
`define PP_REG_STATUS 4'h5
`define PP_REG_ADDR_LO 4'h6
`define PP_REG_ADDR_HI 4'h7
`define PP_REG_MWRITE 4'h8
`define PP_REG_MREAD 4'h9
`define PP_REG_BUF0 4'ha
`define PP_REG_BUF1 4'hb
`define PP_REG_BUF2 4'hc
`define PP_REG_BUF3 4'hd

// reset values and writable masks
`define PP_CS1_BASE_RST 16'h0080
`define PP_CS2_BASE_RST 16'h8080
`define PP_BASE_MASK 16'hff88
`define PP_MODE_MASK 16'hf8ff
`define PP_ZERO16 16'h0000
`define PP_CS1_END 24'h0f_ffff

// control register fields
`define PP_CTRL_PMODE 1:0
`define PP_CTRL_ACKP1 2
`define PP_CTRL_ACKP2 3
`define PP_CTRL_TIMEOUT 12
`define PP_CTRL_ERROR 13
`define PP_CTRL_BUSY 15

// mode register fields
`define PP_MD_ACKM 15:14
`define PP_MD_AMWAIT 13:11
`define PP_MD_SETUP 7:6
`define PP_MD_STROBE 5:2
`define PP_MD_HOLD 1:0

// status register fields
`define PP_ST_IBF 15
`define PP_ST_INPUT_OVERFLOW_FLAG 14
`define PP_ST_INFULL 11:8
`define PP_ST_OBE 7
`define PP_ST_OUTPUT_UNDERFLOW_FLAG 6
`define PP_ST_OUTEMPTY 3:0

// port mode codes
`define PP_PM_MASTER 2'b11
`define PP_PM_ENHANCED 2'b10
`define PP_PM_BUFFERED 2'b01
`define PP_PM_LEGACY 2'b00

// acknowledge mode codes
`define PP_ACK_PLAIN 2'b10
`define PP_ACK_TIMEOUT 2'b01
`define PP_ACK_OFF 2'b00
`define PP_ACK_RSVD 2'b11

// timing figures in quarter cycles; the timeout and alternate wait base in whole cycles
`define PP_QPT 10'h004
`define PP_TIMEOUT_TCY 10'h0ff
`define PP_AMWAIT_BASE 10'h003
`define PP_STRB_WR_EXTRA 10'h002
`define PP_STRB_RD_EXTRA 10'h003
`define PP_ONE_Q 10'h001
`define PP_Q_ZERO 10'h000

`endif

// ===== core/pport_pkg.sv
// types shared by the parallel port design
package pport_pkg;
  // transfer sequencer phases
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_SETUP,
    SEQ_STROBE,
    SEQ_HOLD,
    SEQ_GAP
  } seq_state_type;
endpackage

// ===== core/pport_strobe_sequencer.sv
// quarter-cycle wait-state sequencer for one master transfer
`timescale 1ns/1ns
`include "pport_consts.svh"
module pport_strobe_sequencer (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic qtick_i,
  input wire logic start_i,
  input wire logic read_i,
  input wire logic [1:0] ack_mode_i,
  input wire logic [1:0] setup_i,
  input wire logic [3:0] strobe_i,
  input wire logic [1:0] hold_i,
  input wire logic [2:0] altwait_i,
  input wire logic ack_i,
  output logic busy_o,
  output logic drive_o,
  output logic strobe_o,
  output logic capture_o,
  output logic timeout_o,
  output logic done_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  pport_pkg::seq_state_type state_r; // current phase
  logic [9:0] cnt_r; // quarters spent in phase
  logic rd_r; // transfer direction latched
  logic [9:0] setup_len; // quarters of data setup
  logic [9:0] strb_len; // quarters of strobe
  logic [9:0] hold_len; // quarters of data hold
  logic [9:0] gap_len; // quarters of alternate master wait
  logic [9:0] to_len; // quarters before giving up on ack
  logic last_q; // this tick closes the phase

  // whole cycles to quarters
  function automatic logic [9:0] tcy_q(input logic [9:0] n);
    tcy_q = n * `PP_QPT;
  endfunction

  // ----------------------------------------
  // phase lengths
  // ----------------------------------------
  always_comb begin
    setup_len = tcy_q({8'h00, setup_i}) + `PP_ONE_Q;
    strb_len = tcy_q({6'h00, strobe_i}) + (rd_r ? `PP_STRB_RD_EXTRA : `PP_STRB_WR_EXTRA);
    hold_len = tcy_q({8'h00, hold_i}) + (rd_r ? `PP_Q_ZERO : `PP_ONE_Q);
    gap_len = tcy_q({7'h00, altwait_i} + `PP_AMWAIT_BASE);
    to_len = tcy_q((strobe_i == 4'h0) ? `PP_TIMEOUT_TCY : {6'h00, strobe_i});
  end

  // ----------------------------------------
  // phase sequencing
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state_r <= pport_pkg::SEQ_IDLE;
      cnt_r <= `PP_Q_ZERO;
      rd_r <= 1'b0;
      capture_o <= 1'b0;
      timeout_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      capture_o <= 1'b0;
      timeout_o <= 1'b0;
      done_o <= 1'b0;
      if (qtick_i && state_r != pport_pkg::SEQ_IDLE) begin
        cnt_r <= cnt_r + `PP_ONE_Q;
      end
      unique case (state_r)
        pport_pkg::SEQ_IDLE: begin
          // new transfer starts counting from zero
          if (start_i) begin
            state_r <= pport_pkg::SEQ_SETUP;
            rd_r <= read_i;
            cnt_r <= `PP_Q_ZERO;
          end
        end
        pport_pkg::SEQ_SETUP: begin
          if (last_q) begin
            state_r <= pport_pkg::SEQ_STROBE;
            cnt_r <= `PP_Q_ZERO;
          end
        end
        pport_pkg::SEQ_STROBE: begin
          if ((ack_mode_i == `PP_ACK_PLAIN && ack_i) || (ack_mode_i == `PP_ACK_TIMEOUT && (ack_i || last_q)) ||
              ((ack_mode_i == `PP_ACK_OFF || ack_mode_i == `PP_ACK_RSVD) && last_q)) begin
            capture_o <= rd_r;
            timeout_o <= (ack_mode_i == `PP_ACK_TIMEOUT) && !ack_i;
            cnt_r <= `PP_Q_ZERO;
            if (hold_len == `PP_Q_ZERO) begin
              state_r <= pport_pkg::SEQ_GAP;
              done_o <= 1'b1;
            end else begin
              state_r <= pport_pkg::SEQ_HOLD;
            end
          end
        end
        pport_pkg::SEQ_HOLD: begin
          if (last_q) begin
            state_r <= pport_pkg::SEQ_GAP;
            cnt_r <= `PP_Q_ZERO;
            done_o <= 1'b1;
          end
        end
        pport_pkg::SEQ_GAP: begin
          if (last_q) begin
            state_r <= pport_pkg::SEQ_IDLE;
            cnt_r <= `PP_Q_ZERO;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // phase end and pin levels
  // ----------------------------------------
  always_comb begin
    last_q = 1'b0;
    unique case (state_r)
      pport_pkg::SEQ_IDLE: last_q = 1'b0;
      pport_pkg::SEQ_SETUP: last_q = qtick_i && (cnt_r == setup_len - `PP_ONE_Q);
      pport_pkg::SEQ_STROBE: last_q = qtick_i &&
        (cnt_r == ((ack_mode_i == `PP_ACK_TIMEOUT) ? to_len : strb_len) - `PP_ONE_Q);
      pport_pkg::SEQ_HOLD: last_q = qtick_i && (cnt_r == hold_len - `PP_ONE_Q);
      pport_pkg::SEQ_GAP: last_q = qtick_i && (cnt_r == gap_len - `PP_ONE_Q);
    endcase
  end

  assign busy_o = (state_r != pport_pkg::SEQ_IDLE);
  assign drive_o = (state_r == pport_pkg::SEQ_SETUP) || (state_r == pport_pkg::SEQ_STROBE) ||
                   (state_r == pport_pkg::SEQ_HOLD);
  assign strobe_o = (state_r == pport_pkg::SEQ_STROBE);
endmodule // pport_strobe_sequencer

// ===== core/parallel_port_cs_timing_status.sv
// parallel port: chip selects, wait states, acknowledge and slave buffer status
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "pport_consts.svh"
module parallel_port_cs_timing_status #(
  parameter int QTR_CLKS = 1 // clocks per quarter instruction cycle
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic [23:0] pm_addr_o,
  output logic pm_cs1_o,
  output logic pm_cs2_o,
  output logic pm_rd_o,
  output logic pm_wr_o,
  input wire logic ack_input_i,
  input wire logic host_cs_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [1:0] host_addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_b_o
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [15:0] ctrl_r; // port mode and ack polarity bits
  logic [15:0] cs1_base_r; // first select base
  logic [15:0] cs2_base_r; // second select base
  logic cs2_zero_r; // second base written whole as zero
  logic [15:0] cs1_mode_r; // first select timing
  logic [15:0] cs2_mode_r; // second select timing
  logic [23:0] maddr_r; // master transfer address
  logic [7:0] mwdata_r; // master write byte
  logic [7:0] mrdata_r; // master read byte
  logic timeout_r; // sticky timeout
  logic error_r; // sticky illegal request
  logic sel2_r; // transfer uses second select
  logic [7:0] in_buf [4]; // bytes from the host
  logic [7:0] out_buf [4]; // bytes for the host
  logic [3:0] in_full_r; // per slot unread
  logic [3:0] out_empty_r; // per slot empty
  logic in_ovf_r; // sticky overflow
  logic out_unf_r; // sticky underflow
  logic [1:0] in_ptr_r; // buffered mode write slot
  logic [1:0] out_ptr_r; // buffered mode read slot
  logic [13:0] sync1_r; // first stage, feeds only sync2
  logic [13:0] sync2_r; // second stage
  logic [13:0] sync3_r; // third stage
  logic [13:0] pin_r; // agreed pin levels
  logic hrd_prev_r; // host read seen last cycle
  logic hwr_prev_r; // host write seen last cycle
  logic [7:0] hwdata_r; // last byte seen during host write
  logic [7:0] data_r; // driven data byte
  logic data_oe_b_r; // data drive enable, low drives
  logic [15:0] rdata_r; // read answer
  logic [$clog2(QTR_CLKS+1)-1:0] qdiv_r; // quarter divider
  logic qtick; // one quarter elapsed
  logic [15:0] mode_sel; // timing of chosen select
  logic start_wr; // software asks for a write
  logic start_rd; // software asks for a read
  logic start_ok; // request is legal
  logic hit1; // address in first region
  logic hit2; // address in second region
  logic is_master; // port in master mode
  logic ack_act; // ack after polarity
  logic seq_busy; // transfer or gap in progress
  logic seq_drive; // select asserted
  logic seq_strobe; // strobe asserted
  logic seq_capture; // read byte to take
  logic seq_timeout; // ack never came
  logic seq_done; // transfer ended
  logic seq_read; // latched direction
  logic host_rd; // host read in progress
  logic host_wr; // host write in progress
  logic [1:0] hslot; // slot the host addresses
  logic sw_buf_rd; // software reads a buffer
  logic sw_buf_wr; // software writes a buffer
  logic [1:0] sw_slot; // slot software addresses

  function automatic logic [23:0] region_start(input logic [15:0] b);
    region_start = {b[15:7], 3'b000, b[3], 11'h000};
  endfunction

  // pair of slots sharing a word
  function automatic logic [3:0] pair_mask(input logic [1:0] s);
    pair_mask = s[1] ? 4'b1100 : 4'b0011;
  endfunction

  // ----------------------------------------
  // quarter cycle divider
  // ----------------------------------------
  // one enable pulse per quarter
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      qdiv_r <= '0;
    end else if (qtick) begin
      qdiv_r <= '0;
    end else begin
      qdiv_r <= qdiv_r + 1'b1;
    end
  end
  assign qtick = (qdiv_r == ($clog2(QTR_CLKS+1))'(QTR_CLKS - 1));

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // three stages; a bit moves once stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      pin_r <= '0;
    end else begin
      sync1_r <= {ack_input_i, host_cs_i, host_rd_i, host_wr_i, host_addr_i, data_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r <= (sync3_r & ~(sync2_r ^ sync3_r)) | (pin_r & (sync2_r ^ sync3_r));
    end
  end

  // ----------------------------------------
  // decode and request checks
  // ----------------------------------------
  always_comb begin
    is_master = (ctrl_r[`PP_CTRL_PMODE] == `PP_PM_MASTER);
    hit2 = !cs2_zero_r && (maddr_r >= region_start(cs2_base_r));
    hit1 = !hit2 && (maddr_r >= region_start(cs1_base_r)) &&
           (cs2_zero_r ? (maddr_r <= `PP_CS1_END) : (maddr_r < region_start(cs2_base_r)));
    mode_sel = sel2_r ? cs2_mode_r : cs1_mode_r;
    start_wr = reg_wr_i && reg_addr_i == `PP_REG_MWRITE;
    start_rd = reg_wr_i && reg_addr_i == `PP_REG_MREAD;
    // illegal when not master, busy, reserved ack or unmapped
    start_ok = is_master && !seq_busy && (hit1 || hit2) &&
               ((hit2 ? cs2_mode_r[`PP_MD_ACKM] : cs1_mode_r[`PP_MD_ACKM]) != `PP_ACK_RSVD);
    ack_act = pin_r[13] == (sel2_r ? ctrl_r[`PP_CTRL_ACKP2] : ctrl_r[`PP_CTRL_ACKP1]);
  end

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  pport_strobe_sequencer u_seq (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .qtick_i(qtick),
    .start_i((start_wr || start_rd) && start_ok),
    .read_i(start_rd),
    .ack_mode_i(mode_sel[`PP_MD_ACKM]),
    .setup_i(mode_sel[`PP_MD_SETUP]),
    .strobe_i(mode_sel[`PP_MD_STROBE]),
    .hold_i(mode_sel[`PP_MD_HOLD]),
    .altwait_i(mode_sel[`PP_MD_AMWAIT]),
    .ack_i(ack_act),
    .busy_o(seq_busy),
    .drive_o(seq_drive),
    .strobe_o(seq_strobe),
    .capture_o(seq_capture),
    .timeout_o(seq_timeout),
    .done_o(seq_done)
  );

  // ----------------------------------------
  // master side registers
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sel2_r <= 1'b0;
      seq_read <= 1'b0;
      mrdata_r <= 8'h00;
    end else begin
      // select and direction chosen when accepted
      if ((start_wr || start_rd) && start_ok) begin
        sel2_r <= hit2;
        seq_read <= start_rd;
      end
      // read byte taken as strobe ends
      if (seq_capture) begin
        mrdata_r <= pin_r[7:0];
      end
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ctrl_r <= `PP_ZERO16;
      cs1_base_r <= `PP_CS1_BASE_RST;
      cs2_base_r <= `PP_CS2_BASE_RST;
      cs2_zero_r <= 1'b0;
      cs1_mode_r <= `PP_ZERO16;
      cs2_mode_r <= `PP_ZERO16;
      maddr_r <= 24'h00_0000;
      mwdata_r <= 8'h00;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `PP_REG_CTRL: ctrl_r <= {12'h000, reg_wdata_i[3:0]};
        `PP_REG_CS1_BASE: cs1_base_r <= reg_wdata_i & `PP_BASE_MASK;
        `PP_REG_CS2_BASE: begin
          cs2_base_r <= reg_wdata_i & `PP_BASE_MASK;
          // whole word zero in one write
          cs2_zero_r <= (reg_wdata_i == `PP_ZERO16);
        end
        `PP_REG_CS1_MODE: cs1_mode_r <= reg_wdata_i & `PP_MODE_MASK;
        `PP_REG_CS2_MODE: cs2_mode_r <= reg_wdata_i & `PP_MODE_MASK;
        `PP_REG_ADDR_LO: maddr_r[15:0] <= reg_wdata_i;
        `PP_REG_ADDR_HI: maddr_r[23:16] <= reg_wdata_i[7:0];
        `PP_REG_MWRITE: mwdata_r <= reg_wdata_i[7:0];
        default: begin
          // other offsets store nothing here
        end
      endcase
    end
  end

  // ----------------------------------------
  // sticky master flags
  // ----------------------------------------
  // write one clears; a new event in the same cycle wins
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      timeout_r <= 1'b0;
      error_r <= 1'b0;
    end else begin
      timeout_r <= seq_timeout || (timeout_r &&
        !(reg_wr_i && reg_addr_i == `PP_REG_CTRL && reg_wdata_i[`PP_CTRL_TIMEOUT]));
      error_r <= ((start_wr || start_rd) && !start_ok) || (error_r &&
        !(reg_wr_i && reg_addr_i == `PP_REG_CTRL && reg_wdata_i[`PP_CTRL_ERROR]));
    end
  end

  // ----------------------------------------
  // host strobes and slot choice
  // ----------------------------------------
  always_comb begin
    host_rd = !is_master && pin_r[12] && pin_r[11];
    host_wr = !is_master && pin_r[12] && pin_r[10];
    // slot by mode: address lines, pointer or single
    unique case (ctrl_r[`PP_CTRL_PMODE])
      `PP_PM_ENHANCED: hslot = pin_r[9:8];
      // read pointer kept at read end too, once the strobe has dropped
      `PP_PM_BUFFERED: hslot = (host_rd || hrd_prev_r) ? out_ptr_r : in_ptr_r;
      default: hslot = 2'b00;
    endcase
    sw_buf_rd = reg_rd_i && reg_addr_i >= `PP_REG_BUF0 && reg_addr_i <= `PP_REG_BUF3;
    sw_buf_wr = reg_wr_i && reg_addr_i >= `PP_REG_BUF0 && reg_addr_i <= `PP_REG_BUF3;
    sw_slot = 2'(reg_addr_i - `PP_REG_BUF0);
  end

  // ----------------------------------------
  // slave buffers and flags
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      in_full_r <= 4'h0;
      out_empty_r <= 4'hf;
      in_ovf_r <= 1'b0;
      out_unf_r <= 1'b0;
      in_ptr_r <= 2'b00;
      out_ptr_r <= 2'b00;
      hrd_prev_r <= 1'b0;
      hwr_prev_r <= 1'b0;
      hwdata_r <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        in_buf[i] <= 8'h00;
        out_buf[i] <= 8'h00;
      end
    end else begin
      hrd_prev_r <= host_rd;
      hwr_prev_r <= host_wr;
      // byte followed while host strobe is active; pin may drop at its end
      if (host_wr) begin
        hwdata_r <= pin_r[7:0];
      end
      if (sw_buf_rd) begin
        in_full_r <= in_full_r & ~pair_mask(sw_slot);
      end
      if (sw_buf_wr) begin
        out_buf[sw_slot] <= reg_wdata_i[7:0];
        out_empty_r <= out_empty_r & ~pair_mask(sw_slot);
      end
      // host write commits at strobe end; a full slot drops the byte
      if (hwr_prev_r && !host_wr) begin
        if (!in_full_r[hslot]) begin
          in_buf[hslot] <= hwdata_r;
          in_full_r[hslot] <= 1'b1;
        end
        in_ptr_r <= in_ptr_r + 2'b01;
      end
      // overflow on write to full slot, beats a clear
      if (hwr_prev_r && !host_wr && in_full_r[hslot]) begin
        in_ovf_r <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == `PP_REG_STATUS && reg_wdata_i[`PP_ST_INPUT_OVERFLOW_FLAG]) begin
        in_ovf_r <= 1'b0;
      end
      // host read start on empty slot
      if (host_rd && !hrd_prev_r && out_empty_r[hslot]) begin
        out_unf_r <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == `PP_REG_STATUS && reg_wdata_i[`PP_ST_OUTPUT_UNDERFLOW_FLAG]) begin
        out_unf_r <= 1'b0;
      end
      // host read end marks slot empty, beats a software write
      if (hrd_prev_r && !host_rd) begin
        out_empty_r[hslot] <= 1'b1;
        out_ptr_r <= out_ptr_r + 2'b01;
      end
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rdata_r <= `PP_ZERO16;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `PP_REG_CTRL: rdata_r <= {seq_busy, 1'b0, error_r, timeout_r, 8'h00, ctrl_r[3:0]};
        `PP_REG_CS1_BASE: rdata_r <= cs1_base_r;
        `PP_REG_CS2_BASE: rdata_r <= cs2_base_r;
        `PP_REG_CS1_MODE: rdata_r <= cs1_mode_r;
        `PP_REG_CS2_MODE: rdata_r <= cs2_mode_r;
        `PP_REG_STATUS: rdata_r <= {&in_full_r, in_ovf_r, 2'b00, in_full_r,
                                    &out_empty_r, out_unf_r, 2'b00, out_empty_r};
        `PP_REG_ADDR_LO: rdata_r <= maddr_r[15:0];
        `PP_REG_ADDR_HI: rdata_r <= {8'h00, maddr_r[23:16]};
        `PP_REG_MWRITE: rdata_r <= {8'h00, mrdata_r};
        `PP_REG_BUF0, `PP_REG_BUF1, `PP_REG_BUF2, `PP_REG_BUF3: rdata_r <= {8'h00, in_buf[sw_slot]};
        default: rdata_r <= `PP_ZERO16;
      endcase
    end else begin
      rdata_r <= `PP_ZERO16;
    end
  end
  assign reg_rdata_o = rdata_r;

  // ----------------------------------------
  // pins
  // ----------------------------------------
  // data bus: master write byte or host read byte
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      data_r <= 8'h00;
      data_oe_b_r <= 1'b1;
    end else if ((start_wr && start_ok) || (seq_drive && !seq_read)) begin
      // byte out with the select, so setup counts at the pins
      data_r <= start_wr ? reg_wdata_i[7:0] : mwdata_r;
      data_oe_b_r <= 1'b0;
    end else if (host_rd) begin
      data_r <= out_buf[hslot];
      data_oe_b_r <= 1'b0;
    end else begin
      data_oe_b_r <= 1'b1;
    end
  end
  assign data_o = data_r;
  assign data_oe_b_o = data_oe_b_r;
  assign pm_addr_o = maddr_r;
  assign pm_cs1_o = seq_drive && !sel2_r;
  assign pm_cs2_o = seq_drive && sel2_r;
  assign pm_rd_o = seq_strobe && seq_read;
  assign pm_wr_o = seq_strobe && !seq_read;
endmodule // parallel_port_cs_timing_status

// ===== testbench/pport_chk_assertions.sv
// pin checks on the master side of the parallel port
`timescale 1ns/1ns
module pport_chk #(
  parameter int QTR_CLKS = 1 // figures below assume one clock a quarter
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [23:0] pm_addr_o,
  input wire logic pm_cs1_o,
  input wire logic pm_cs2_o,
  input wire logic pm_rd_o,
  input wire logic pm_wr_o,
  input wire logic data_oe_b_o
);
  wire cs = pm_cs1_o | pm_cs2_o; // either select
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  AST_CS_ONE: assert property (!(pm_cs1_o && pm_cs2_o)) else $error("two selects");
  AST_STB_CS: assert property ((pm_rd_o || pm_wr_o) |-> cs) else $error("strobe without select");
  AST_SETUP: assert property ($rose(cs) |-> !(pm_rd_o || pm_wr_o)) else $error("no setup");
  AST_WR_LEN: assert property ($rose(pm_wr_o) |-> pm_wr_o[*2]) else $error("write strobe short");
  AST_RD_LEN: assert property ($rose(pm_rd_o) |-> pm_rd_o[*3]) else $error("read strobe short");
  AST_WR_HOLD: assert property ($fell(pm_wr_o) |-> cs && !data_oe_b_o) else $error("no hold");
  AST_WR_SETUP: assert property ($rose(pm_wr_o) |-> !$past(data_oe_b_o)) else $error("data not set up");
  AST_GAP: assert property ($fell(cs) |-> !cs[*8]) else $error("gap short");
  AST_ADDR: assert property (cs && $past(cs) |-> $stable(pm_addr_o)) else $error("address moved");
  cover property ($rose(pm_wr_o));
  cover property ($rose(pm_rd_o) ##3 pm_rd_o);
  cover property ($fell(cs) ##12 !cs);
endmodule // pport_chk

// ===== testbench/pport_mem_model.sv
// byte memory on the master pins, answers with acknowledge
`timescale 1ns/1ns
module pport_mem_model (
  input wire logic mclk_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [23:0] addr_i,
  input wire logic [7:0] wd_i,
  input wire logic ack_en_i,
  output logic ack_o,
  output logic [7:0] q_o
);
  logic [7:0] mem [256]; // low address byte only
  logic [7:0] last = 8'h00; // last byte handed out
  int hi = 0; // clocks into the strobe
  // store on write, remember read byte
  always @(posedge mclk_i) begin
    hi <= (rd_i || wr_i) ? hi + 1 : 0;
    if (wr_i) mem[addr_i[7:0]] <= wd_i;
    if (rd_i) last <= mem[addr_i[7:0]];
  end
  assign ack_o = ack_en_i && hi >= 2;
  // released bus never repeats the last byte
  assign q_o = rd_i ? mem[addr_i[7:0]] : ~last;
endmodule // pport_mem_model

// ===== testbench/parallel_port_cs_timing_status_test.sv
// self-checking bench for the parallel port
`timescale 1ns/1ns
module parallel_port_cs_timing_status_test;
  logic mclk_i = 0, rst_b_i = 0, wr = 0, rd = 0, hcs = 0, hrd = 0, hwr = 0, ack_en = 0;
  logic [3:0] a = 0;
  logic [15:0] wd = 0, rq;
  logic [23:0] pa;
  logic c1, c2, prd, pwr, ack, oe_b;
  logic [7:0] dq, mq, hd = 0;
  int err_total = 0, cmp_count = 0, n1 = 0, nst = 0;
  always #5 mclk_i = ~mclk_i;
  parallel_port_cs_timing_status dut (.mclk_i, .rst_b_i, .reg_addr_i(a), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rq), .pm_addr_o(pa), .pm_cs1_o(c1), .pm_cs2_o(c2), .pm_rd_o(prd), .pm_wr_o(pwr),
    .ack_input_i(ack), .host_cs_i(hcs), .host_rd_i(hrd), .host_wr_i(hwr), .host_addr_i(2'b00),
    .data_i(!oe_b ? dq : prd ? mq : hd), .data_o(dq), .data_oe_b_o(oe_b));
  pport_mem_model mem (.mclk_i, .rd_i(prd), .wr_i(pwr), .addr_i(pa), .wd_i(dq), .ack_en_i(ack_en), .ack_o(ack),
    .q_o(mq));
  // count first-select and strobe clocks
  always @(posedge mclk_i) begin
    n1 <= n1 + c1;
    nst <= nst + (prd | pwr);
  end
  task automatic cyc(int n = 1);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(logic [3:0] x, logic [15:0] d);
    a <= x;
    wd <= d;
    wr <= 1;
    cyc();
    wr <= 0;
    #1;
  endtask
  task automatic rreg(logic [3:0] x, logic [15:0] e);
    a <= x;
    rd <= 1;
    cyc();
    rd <= 0;
    #1 chk(rq, e);
  endtask
  // start a transfer, poll busy with a bound
  task automatic xfer(logic [3:0] x, logic [15:0] d);
    wreg(x, d);
    cyc(2);
    repeat (2000) begin
      a <= 4'h0;
      rd <= 1;
      cyc();
      rd <= 0;
      #1 if (rq[15] === 1'b0) break;
    end
    chk(16'(rq[15]), 16'h0000);
  endtask
  task automatic timed(logic [3:0] x, int ecs, int est);
    int c0 = n1, s0 = nst;
    xfer(x, 16'h00a5);
    chk(16'(n1 - c0), 16'(ecs));
    chk(16'(nst - s0), 16'(est));
  endtask
  task automatic host(logic w);
    hd <= 8'h3c;
    hcs <= 1;
    hwr <= w;
    hrd <= !w;
    cyc(4);
    {hcs, hwr, hrd} <= 3'b000;
    cyc(8);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    cyc(2);
    rst_b_i <= 1;
    cyc();
    rreg(4'h2, 16'h8080);
    rreg(4'h5, 16'h008f);
    rreg(4'hf, 16'h0000);
    wreg(4'h0, 16'h000f);
    wreg(4'h6, 16'h9000);
    wreg(4'h1, 16'h00ff);
    rreg(4'h1, 16'h0088);
    wreg(4'h3, 16'hffff);
    rreg(4'h3, 16'hf8ff);
    xfer(4'h8, 16'h00a5);
    rreg(4'h0, 16'h200f);
    wreg(4'h3, 16'h0049);
    timed(4'h8, 20, 10);
    timed(4'h9, 20, 11);
    rreg(4'h8, 16'h00a5);
    wreg(4'h3, 16'h4004);
    timed(4'h9, 5, 4);
    wreg(4'h3, 16'h4000);
    timed(4'h9, 1021, 1020);
    rreg(4'h0, 16'h300f);
    wreg(4'h0, 16'h300f);
    wreg(4'h3, 16'h8000);
    ack_en <= 1;
    xfer(4'h9, 16'h0000);
    rreg(4'h0, 16'h000f);
    wreg(4'h3, 16'h0000);
    wreg(4'h2, 16'h0000);
    wreg(4'h7, 16'h000f);
    timed(4'h8, 4, 2);
    wreg(4'h7, 16'h0010);
    xfer(4'h8, 16'h0000);
    rreg(4'h0, 16'h200f);
    wreg(4'h0, 16'h0001);
    repeat (5) host(1);
    rreg(4'h5, 16'hcf8f);
    rreg(4'ha, 16'h003c);
    rreg(4'h5, 16'h4c8f);
    host(0);
    rreg(4'h5, 16'h4ccf);
    wreg(4'hb, 16'h0077);
    rreg(4'h5, 16'h4c4c);
    host(1);
    host(0);
    rreg(4'h5, 16'h4e4e);
    print_verdict();
  end
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule // parallel_port_cs_timing_status_test
bind parallel_port_cs_timing_status pport_chk #(.QTR_CLKS(QTR_CLKS)) u_chk (.mclk_i, .rst_b_i, .pm_addr_o,
  .pm_cs1_o, .pm_cs2_o, .pm_rd_o, .pm_wr_o, .data_oe_b_o);
